/* File: verilog/fau_unit.sv */
// Notes on behaviour
// - Magnitude operation returns absolute value of its source three cycles after issue.
// - Operands and results are IEEE single-precision words in 32-bit registers.
// - Magnitude of a denormal source yields zero and raises input-flush flag.
// - Exceptions from magnitude operation set matching status-word flags.
// - Signalling NaN gives all-ones quiet NaN plus invalid; quiet NaN raises nothing.
// - Status flags are sticky; only an explicit status write or srst clears them.
// - Flag update lands in the same cycle as the destination write.
// - Simultaneous flag sets OR together with the existing flag value, or with the written value during a status write.
// - Guard least significant bit alone decides the destination write; one writes.
// - False guard on computing operation leaves destination and flags untouched.
// - Magnitude probe writes the flag vector magnitude would produce, latency three.
// - Vector bits: zero-divide, inexact, underflow, overflow, invalid, input-flush, output-flush.
// - Probe operations never modify status-word flags.
// - Magnitude probe sets input-flush bit for a denormal source.
// - Add operation returns the single-precision sum three cycles after issue.
// - Add rounds using the rounding_mode input sampled at issue, not the status word.
// - Denormal add sources become zero and raise input-flush flag.
// - Denormal add result becomes zero and raises output-flush flag.
// - Exceptions from add set the matching status-word flags.
// - Add overflow returns infinity, or the largest finite value for RM_ZERO, RM_UP on a negative or RM_DOWN on a positive sum, with overflow and inexact flags.
// - Add probe writes the add flag vector without touching flags, latency three.
`timescale 1ns/1ps
`default_nettype none
module fau_unit
    import fau_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic issue_valid,
    input wire logic [7:0] issue_opcode,
    input wire logic [31:0] first_source_register,
    input wire logic [31:0] second_source_register,
    input wire logic issue_guard_given,
    input wire logic [31:0] issue_guard_word,
    input wire logic [DEST_W-1:0] issue_dest,
    input wire logic [1:0] rounding_mode,
    input wire logic psw_write,
    input wire logic [FLAG_W-1:0] psw_write_flags,
    input wire logic other_flag_valid,
    input wire logic [FLAG_W-1:0] other_flag_set,
    output logic wb_valid,
    output logic [DEST_W-1:0] wb_dest,
    output logic [31:0] wb_data,
    output logic [FLAG_W-1:0] program_status_word
);
    // Stage 1: operands captured at issue
    logic s1_valid_q, s1_valid_d;
    logic s1_add_q, s1_add_d;
    logic s1_probe_q, s1_probe_d;
    logic s1_we_q, s1_we_d;
    logic [31:0] s1_a_q, s1_a_d;
    logic [31:0] s1_b_q, s1_b_d;
    logic [1:0] s1_rm_q, s1_rm_d;
    logic [DEST_W-1:0] s1_dest_q, s1_dest_d;
    logic known_op;

    assign known_op = (issue_opcode == OPC_ADD) || (issue_opcode == OPC_ADD_PROBE)
        || (issue_opcode == OPC_ABS) || (issue_opcode == OPC_ABS_PROBE);

    always_comb begin
        s1_valid_d = issue_valid && known_op;
        s1_add_d = (issue_opcode == OPC_ADD) || (issue_opcode == OPC_ADD_PROBE);
        s1_probe_d = (issue_opcode == OPC_ADD_PROBE) || (issue_opcode == OPC_ABS_PROBE);
        s1_we_d = !issue_guard_given || issue_guard_word[0];
        s1_a_d = first_source_register;
        s1_b_d = second_source_register;
        // Mode is sampled at issue so a later status write cannot change an op in flight
        s1_rm_d = rounding_mode;
        s1_dest_d = issue_dest;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s1_valid_q <= 1'b0;
            s1_add_q <= 1'b0;
            s1_probe_q <= 1'b0;
            s1_we_q <= 1'b0;
            s1_a_q <= 32'h0000_0000;
            s1_b_q <= 32'h0000_0000;
            s1_rm_q <= RM_NEAR;
            s1_dest_q <= '0;
        end else begin
            s1_valid_q <= s1_valid_d;
            s1_add_q <= s1_add_d;
            s1_probe_q <= s1_probe_d;
            s1_we_q <= s1_we_d;
            s1_a_q <= s1_a_d;
            s1_b_q <= s1_b_d;
            s1_rm_q <= s1_rm_d;
            s1_dest_q <= s1_dest_d;
        end
    end

    // Operand classification, one copy per source
    logic [31:0] src [2];
    logic [31:0] flushed [2];
    logic [1:0] is_den, is_nan, is_snan, is_inf;

    assign src[0] = s1_a_q;
    assign src[1] = s1_b_q;

    genvar gi;
    for (gi = 0; gi < 2; gi++) begin : g_cls
        assign is_den[gi] = src[gi][30:23] == EXP_ZERO && src[gi][22:0] != 23'h00_0000;
        assign is_nan[gi] = src[gi][30:23] == EXP_ONES && src[gi][22:0] != 23'h00_0000;
        assign is_snan[gi] = is_nan[gi] && !src[gi][22];
        assign is_inf[gi] = src[gi][30:23] == EXP_ONES && src[gi][22:0] == 23'h00_0000;
        assign flushed[gi] = is_den[gi] ? {src[gi][31], 31'h0000_0000} : src[gi];
    end

    function automatic logic [4:0] lead_zeros(input logic [26:0] v);
        logic [4:0] n;
        logic hit;
        n = 5'h00;
        hit = 1'b0;
        for (int k = 26; k >= 0; k--) begin
            if (!hit && v[k]) begin
                hit = 1'b1;
                n = 5'(26 - k);
            end
        end
        return n;
    endfunction

    // Add datapath: align, sum, normalise
    logic swap;
    logic [31:0] big, lesser;
    logic [7:0] exp_gap;
    logic [26:0] m_big, m_small, m_shift, m_lost;
    logic [27:0] sum;
    logic [4:0] lz;
    logic [26:0] norm_mant;
    logic signed [9:0] norm_exp;
    logic zero_sign;
    logic [31:0] rnd_word;
    logic rnd_over, rnd_under, rnd_inexact, rnd_flush;

    always_comb begin
        swap = flushed[1][30:0] > flushed[0][30:0];
        big = swap ? flushed[1] : flushed[0];
        lesser = swap ? flushed[0] : flushed[1];
        exp_gap = big[30:23] - lesser[30:23];
        m_big = {big[30:23] != EXP_ZERO, big[22:0], 3'h0};
        m_small = {lesser[30:23] != EXP_ZERO, lesser[22:0], 3'h0};
        if (exp_gap >= ALIGN_LIMIT) begin
            m_shift = 27'h000_0000;
            m_lost = m_small;
        end else begin
            m_shift = m_small >> exp_gap;
            m_lost = m_small & ((27'h000_0001 << exp_gap) - 27'h000_0001);
        end
        m_shift[0] = m_shift[0] | (|m_lost);
        if (big[31] ^ lesser[31]) begin
            sum = {1'b0, m_big} - {1'b0, m_shift};
        end else begin
            sum = {1'b0, m_big} + {1'b0, m_shift};
        end
        lz = lead_zeros(sum[26:0]);
        if (sum[27]) begin
            norm_mant = {sum[27:2], sum[1] | sum[0]};
            norm_exp = $signed({2'b00, big[30:23]}) + 10'sh001;
        end else begin
            norm_mant = sum[26:0] << lz;
            norm_exp = $signed({2'b00, big[30:23]}) - $signed({5'h00, lz});
        end
        // Exact zero: positive unless both negative, or signs differ and rounding toward minus
        zero_sign = (big[31] & lesser[31]) | ((big[31] ^ lesser[31]) & (s1_rm_q == RM_DOWN));
    end

    fau_round u_round (
        .sign(big[31]),
        .exponent(norm_exp),
        .mant(norm_mant),
        .rounding_mode(s1_rm_q),
        .word(rnd_word),
        .overflow(rnd_over),
        .underflow(rnd_under),
        .inexact(rnd_inexact),
        .out_flush(rnd_flush)
    );

    // Stage 2: result word and exception vector
    logic s2_valid_q, s2_valid_d;
    logic s2_probe_q, s2_probe_d;
    logic s2_we_q, s2_we_d;
    logic [DEST_W-1:0] s2_dest_q, s2_dest_d;
    logic [31:0] s2_res_q, s2_res_d;
    logic [FLAG_W-1:0] s2_vec_q, s2_vec_d;

    always_comb begin
        s2_valid_d = s1_valid_q;
        s2_probe_d = s1_probe_q;
        s2_we_d = s1_we_q;
        s2_dest_d = s1_dest_q;
        s2_vec_d = FLAGS_RESET;
        s2_res_d = 32'h0000_0000;
        if (!s1_add_q) begin
            s2_vec_d[FLG_IN_FLUSH] = is_den[0];
            if (is_nan[0]) begin
                s2_res_d = QUIET_NAN;
                s2_vec_d[FLG_BAD_OP] = is_snan[0];
            end else begin
                s2_res_d = {1'b0, flushed[0][30:0]};
            end
        end else begin
            s2_vec_d[FLG_IN_FLUSH] = |is_den;
            if (|is_nan) begin
                s2_res_d = QUIET_NAN;
                s2_vec_d[FLG_BAD_OP] = |is_snan;
            end else if (&is_inf && (s1_a_q[31] ^ s1_b_q[31])) begin
                s2_res_d = QUIET_NAN;
                s2_vec_d[FLG_BAD_OP] = 1'b1;
            end else if (is_inf[0]) begin
                s2_res_d = s1_a_q;
            end else if (is_inf[1]) begin
                s2_res_d = s1_b_q;
            end else if (sum == 28'h000_0000) begin
                s2_res_d = {zero_sign, 31'h0000_0000};
            end else begin
                s2_res_d = rnd_word;
                s2_vec_d[FLG_OVER] = rnd_over;
                s2_vec_d[FLG_UNDER] = rnd_under;
                s2_vec_d[FLG_INEXACT] = rnd_inexact;
                s2_vec_d[FLG_OUT_FLUSH] = rnd_flush;
            end
        end
        // Probe forms return the vector, zero-extended, instead of the value
        if (s1_probe_q) begin
            s2_res_d = {25'h000_0000, s2_vec_d};
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s2_valid_q <= 1'b0;
            s2_probe_q <= 1'b0;
            s2_we_q <= 1'b0;
            s2_dest_q <= '0;
            s2_res_q <= 32'h0000_0000;
            s2_vec_q <= FLAGS_RESET;
        end else begin
            s2_valid_q <= s2_valid_d;
            s2_probe_q <= s2_probe_d;
            s2_we_q <= s2_we_d;
            s2_dest_q <= s2_dest_d;
            s2_res_q <= s2_res_d;
            s2_vec_q <= s2_vec_d;
        end
    end

    // Stage 3: write-back and sticky flags, loaded on the same edge
    logic wb_valid_q, wb_valid_d;
    logic [DEST_W-1:0] wb_dest_q, wb_dest_d;
    logic [31:0] wb_data_q, wb_data_d;
    logic [FLAG_W-1:0] flags_q, flags_d;
    logic [FLAG_W-1:0] own_set;
    logic commit;

    always_comb begin
        commit = s2_valid_q && s2_we_q;
        wb_valid_d = commit;
        wb_dest_d = commit ? s2_dest_q : wb_dest_q;
        wb_data_d = commit ? s2_res_q : wb_data_q;
        own_set = (commit && !s2_probe_q) ? s2_vec_q : FLAGS_RESET;
        // A set arriving with a status write survives the clear
        flags_d = (psw_write ? psw_write_flags : flags_q)
            | own_set
            | (other_flag_valid ? other_flag_set : FLAGS_RESET);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wb_valid_q <= 1'b0;
            wb_dest_q <= '0;
            wb_data_q <= 32'h0000_0000;
            flags_q <= FLAGS_RESET;
        end else begin
            wb_valid_q <= wb_valid_d;
            wb_dest_q <= wb_dest_d;
            wb_data_q <= wb_data_d;
            flags_q <= flags_d;
        end
    end

    assign wb_valid = wb_valid_q;
    assign wb_dest = wb_dest_q;
    assign wb_data = wb_data_q;
    assign program_status_word = flags_q;
endmodule
`default_nettype wire

/* File: verilog/fau_pkg.sv */
`default_nettype none
package fau_pkg;
    // Operation codes seen on the issue slot
    localparam logic [7:0] OPC_ADD = 8'h16;
    localparam logic [7:0] OPC_ADD_PROBE = 8'h70;
    localparam logic [7:0] OPC_ABS = 8'h73;
    localparam logic [7:0] OPC_ABS_PROBE = 8'h74;
    localparam int LATENCY = 3;
    localparam int DEST_W = 7;
    localparam int FLAG_W = 7;
    // Exception vector bit positions
    localparam int FLG_DIV_ZERO = 0;
    localparam int FLG_INEXACT = 1;
    localparam int FLG_UNDER = 2;
    localparam int FLG_OVER = 3;
    localparam int FLG_BAD_OP = 4;
    localparam int FLG_IN_FLUSH = 5;
    localparam int FLG_OUT_FLUSH = 6;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 7'h00;
    // Rounding mode encoding
    localparam logic [1:0] RM_NEAR = 2'h0;
    localparam logic [1:0] RM_ZERO = 2'h1;
    localparam logic [1:0] RM_UP = 2'h2;
    localparam logic [1:0] RM_DOWN = 2'h3;
    localparam logic [31:0] QUIET_NAN = 32'hffff_ffff;
    localparam logic [31:0] POS_INF = 32'h7f80_0000;
    localparam logic [31:0] MAX_FINITE = 32'h7f7f_ffff;
    localparam logic [7:0] EXP_ONES = 8'hff;
    localparam logic [7:0] EXP_ZERO = 8'h00;
    localparam logic [7:0] ALIGN_LIMIT = 8'h1b;
    localparam logic [9:0] EXP_OVF_LIMIT = 10'h0ff;
endpackage
`default_nettype wire

/* File: verilog/fau_round.sv */
`timescale 1ns/1ps
`default_nettype none
module fau_round
    import fau_pkg::*;
(
    input wire logic sign,
    input wire logic signed [9:0] exponent,
    input wire logic [26:0] mant,
    input wire logic [1:0] rounding_mode,
    output logic [31:0] word,
    output logic overflow,
    output logic underflow,
    output logic inexact,
    output logic out_flush
);
    logic lost;
    logic bump;
    logic [24:0] rounded;
    logic signed [9:0] exp_r;
    logic to_max;

    always_comb begin
        lost = |mant[2:0];
        bump = 1'b0;
        case (rounding_mode)
            RM_NEAR: bump = mant[2] & (mant[1] | mant[0] | mant[3]);
            RM_ZERO: bump = 1'b0;
            RM_UP: bump = ~sign & lost;
            RM_DOWN: bump = sign & lost;
            default: bump = 1'b0;
        endcase
        rounded = {1'b0, mant[26:3]} + {24'h00_0000, bump};
        exp_r = exponent + {9'h000, rounded[24]};
        to_max = (rounding_mode == RM_ZERO) || (rounding_mode == RM_UP && sign)
            || (rounding_mode == RM_DOWN && !sign);
        word = {sign, exp_r[7:0], rounded[24] ? 23'h00_0000 : rounded[22:0]};
        overflow = 1'b0;
        underflow = 1'b0;
        inexact = lost;
        out_flush = 1'b0;
        // Flush is decided before rounding: a tiny result never rounds up into range
        if (exponent < 10'sh001) begin
            word = {sign, 31'h0000_0000};
            underflow = 1'b1;
            inexact = 1'b1;
            out_flush = 1'b1;
        end else if (exp_r >= $signed(EXP_OVF_LIMIT)) begin
            word = to_max ? {sign, MAX_FINITE[30:0]} : {sign, POS_INF[30:0]};
            overflow = 1'b1;
            inexact = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/fau_unit_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module fau_unit_monitor
    import fau_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic issue_valid,
    input wire logic [7:0] issue_opcode,
    input wire logic [31:0] first_source_register,
    input wire logic [31:0] second_source_register,
    input wire logic issue_guard_given,
    input wire logic [31:0] issue_guard_word,
    input wire logic [DEST_W-1:0] issue_dest,
    input wire logic [1:0] rounding_mode,
    input wire logic psw_write,
    input wire logic [FLAG_W-1:0] psw_write_flags,
    input wire logic other_flag_valid,
    input wire logic [FLAG_W-1:0] other_flag_set,
    input wire logic wb_valid,
    input wire logic [DEST_W-1:0] wb_dest,
    input wire logic [31:0] wb_data,
    input wire logic [FLAG_W-1:0] program_status_word
);
    logic probe_op;
    logic take_ok;
    assign probe_op = issue_opcode == OPC_ABS_PROBE || issue_opcode == OPC_ADD_PROBE;
    assign take_ok = (probe_op || issue_opcode == OPC_ABS || issue_opcode == OPC_ADD)
        && (!issue_guard_given || issue_guard_word[0]);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_take; issue_valid && take_ok; endsequence
    sequence s_probe; issue_valid && take_ok && probe_op; endsequence
    // Commit edge free of other flag sources
    sequence s_quiet_probe; s_probe ##2 !psw_write && !other_flag_valid; endsequence

    a_reset_clears: assert property (disable iff (1'b0) srst |=> !wb_valid && program_status_word == FLAGS_RESET)
        else $error("reset left outputs set");
    a_op_latency: assert property (s_take |-> ##3 wb_valid && wb_dest == $past(issue_dest, 3))
        else $error("result not written three cycles after issue");
    a_refused_quiet: assert property (issue_valid && !take_ok |-> ##3 !wb_valid)
        else $error("refused operation wrote a result");
    a_probe_vector: assert property (s_probe |-> ##3 wb_data[31:FLAG_W] == '0)
        else $error("probe vector upper bits not zero");
    a_probe_flags: assert property (s_quiet_probe |=> $stable(program_status_word))
        else $error("probe changed status flags");
    a_flags_sticky: assert property (!psw_write |=>
        (program_status_word & $past(program_status_word)) == $past(program_status_word))
        else $error("status flag cleared without a write");
    a_flag_cause: assert property (!psw_write && !other_flag_valid ##1 !wb_valid |-> $stable(program_status_word))
        else $error("status flags moved without a write back");
    a_write_loads: assert property (psw_write && !other_flag_valid |=> wb_valid || program_status_word == $past(psw_write_flags))
        else $error("status write not loaded");
    a_other_sets: assert property (other_flag_valid |=>
        (program_status_word & $past(other_flag_set)) == $past(other_flag_set))
        else $error("other unit flags not merged");
endmodule
bind fau_unit fau_unit_monitor fau_unit_monitor_i (
    .clock(clock), .srst(srst), .issue_valid(issue_valid), .issue_opcode(issue_opcode),
    .first_source_register(first_source_register), .second_source_register(second_source_register),
    .issue_guard_given(issue_guard_given), .issue_guard_word(issue_guard_word), .issue_dest(issue_dest),
    .rounding_mode(rounding_mode), .psw_write(psw_write), .psw_write_flags(psw_write_flags),
    .other_flag_valid(other_flag_valid), .other_flag_set(other_flag_set), .wb_valid(wb_valid),
    .wb_dest(wb_dest), .wb_data(wb_data), .program_status_word(program_status_word)
);
`default_nettype wire

/* File: tb/fau_issue_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fau_issue_model
    import fau_pkg::*;
(
    input wire logic clock,
    output logic issue_valid,
    output logic [7:0] issue_opcode,
    output logic [31:0] first_source_register,
    output logic [31:0] second_source_register,
    output logic issue_guard_given,
    output logic [31:0] issue_guard_word,
    output logic [DEST_W-1:0] issue_dest,
    output logic [1:0] rounding_mode,
    input wire logic wb_valid,
    input wire logic [DEST_W-1:0] wb_dest,
    input wire logic [31:0] wb_data
);
    logic [31:0] rf [0:127];
    task automatic drive(input logic v, input logic [7:0] op, input logic [31:0] a, input logic [31:0] b,
        input logic gg, input logic [31:0] gw, input logic [1:0] rm, input logic [DEST_W-1:0] d);
        issue_valid = v;
        issue_opcode = op;
        first_source_register = a;
        second_source_register = b;
        issue_guard_given = gg;
        issue_guard_word = gw;
        rounding_mode = rm;
        issue_dest = d;
    endtask
    task automatic issue(input logic [7:0] op, input logic [31:0] a, input logic [31:0] b,
        input logic gg, input logic [31:0] gw, input logic [1:0] rm, input logic [DEST_W-1:0] d);
        @(negedge clock);
        drive(1'b1, op, a, b, gg, gw, rm, d);
    endtask
    // Released operands flip so a late sample cannot match by luck
    task automatic idle();
        @(negedge clock);
        drive(1'b0, ~issue_opcode, ~first_source_register, ~second_source_register, ~issue_guard_given,
            ~issue_guard_word, ~rounding_mode, ~issue_dest);
    endtask
    initial begin
        drive(1'b0, 8'h00, 32'h0, 32'h0, 1'b0, 32'h0, RM_NEAR, '0);
        foreach (rf[i]) begin
            rf[i] = 32'hdead_beef;
        end
    end
    always @(posedge clock) begin
        if (wb_valid === 1'b1) begin
            rf[wb_dest] <= wb_data;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_fau_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_fau_unit
    import fau_pkg::*;
;
    typedef struct {
        logic [7:0] op;
        logic [31:0] a, b;
        logic gg;
        logic [31:0] gw;
        logic [1:0] rm;
        logic [31:0] e;
        logic [6:0] f;
    } fau_row_type;
    // Untouched register marker
    localparam logic [31:0] NW = 32'hdead_beef;
    logic clock, srst, psw_write, other_flag_valid, issue_valid, issue_guard_given, wb_valid;
    logic [FLAG_W-1:0] psw_write_flags, other_flag_set, program_status_word;
    logic [7:0] issue_opcode;
    logic [31:0] first_source_register, second_source_register, issue_guard_word, wb_data;
    logic [DEST_W-1:0] issue_dest, wb_dest;
    logic [1:0] rounding_mode;
    int err_total = 0;
    int compares = 0;
    fau_row_type rows[$];

    always #5 clock = ~clock;

    fau_unit fau_unit_i (.clock(clock), .srst(srst), .issue_valid(issue_valid), .issue_opcode(issue_opcode),
        .first_source_register(first_source_register), .second_source_register(second_source_register),
        .issue_guard_given(issue_guard_given), .issue_guard_word(issue_guard_word), .issue_dest(issue_dest),
        .rounding_mode(rounding_mode), .psw_write(psw_write), .psw_write_flags(psw_write_flags),
        .other_flag_valid(other_flag_valid), .other_flag_set(other_flag_set), .wb_valid(wb_valid),
        .wb_dest(wb_dest), .wb_data(wb_data), .program_status_word(program_status_word));
    fau_issue_model fau_issue_model_i (.clock(clock), .issue_valid(issue_valid), .issue_opcode(issue_opcode),
        .first_source_register(first_source_register), .second_source_register(second_source_register),
        .issue_guard_given(issue_guard_given), .issue_guard_word(issue_guard_word), .issue_dest(issue_dest),
        .rounding_mode(rounding_mode), .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input logic w, input logic [6:0] wf, input logic o, input logic [6:0] os);
        @(negedge clock);
        psw_write = w;
        psw_write_flags = wf;
        other_flag_valid = o;
        other_flag_set = os;
        @(negedge clock);
        psw_write = 1'b0;
        other_flag_valid = 1'b0;
    endtask
    function automatic void r(logic [7:0] op, logic [31:0] a, logic [31:0] e, logic [6:0] f,
        logic [31:0] b = 32'h0, logic gg = 1'b0, logic [31:0] gw = 32'h0, logic [1:0] rm = RM_NEAR);
        rows.push_back('{op, a, b, gg, gw, rm, e, f});
    endfunction
    task automatic summarize();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        summarize();
    end

    initial begin
        clock = 1'b0;
        srst = 1'b1;
        psw_write = 1'b0;
        psw_write_flags = 7'h00;
        other_flag_valid = 1'b0;
        other_flag_set = 7'h00;
        r(OPC_ABS, 32'h4040_0000, 32'h4040_0000, 7'h00);
        r(OPC_ABS, 32'hbf80_0000, 32'h3f80_0000, 7'h00);
        r(OPC_ABS, 32'h0040_0000, 32'h0, 7'h20);
        r(OPC_ABS, 32'hffff_ffff, 32'hffff_ffff, 7'h00);
        r(OPC_ABS, 32'hffbf_ffff, 32'hffff_ffff, 7'h10);
        r(OPC_ABS, 32'hff7f_ffff, NW, 7'h00, 32'h0, 1'b1, 32'hffff_fffe);
        r(OPC_ABS, 32'hff7f_ffff, 32'h7f7f_ffff, 7'h00, 32'h0, 1'b1, 32'h0000_0001);
        r(OPC_ABS, 32'hff7f_ffff, 32'h7f7f_ffff, 7'h00);
        r(OPC_ABS_PROBE, 32'h0040_0000, 32'h0000_0020, 7'h00);
        r(OPC_ABS_PROBE, 32'hffbf_ffff, 32'h0000_0010, 7'h00);
        r(OPC_ABS_PROBE, 32'h0040_0000, NW, 7'h00, 32'h0, 1'b1, 32'h0);
        r(OPC_ADD, 32'hc040_0000, 32'hc000_0000, 7'h00, 32'h3f80_0000);
        r(OPC_ADD, 32'h4040_0000, 32'h8000_0000, 7'h00, 32'hc040_0000, 1'b0, 32'h0, RM_DOWN);
        r(OPC_ADD, 32'h4040_0000, NW, 7'h00, 32'h0080_0000, 1'b1, 32'h0);
        r(OPC_ADD, 32'h4040_0000, 32'h4040_0000, 7'h02, 32'h0080_0000, 1'b1, 32'h0000_0001);
        r(OPC_ADD, 32'h4040_0000, 32'h4040_0000, 7'h20, 32'h0040_0000);
        r(OPC_ADD, 32'h00c0_0000, 32'h0, 7'h46, 32'h8080_0000);
        r(OPC_ADD, 32'h7f80_0000, 32'hffff_ffff, 7'h10, 32'hff80_0000);
        r(OPC_ADD, 32'h7f7f_ffff, 32'h7f80_0000, 7'h0a, 32'h7f7f_ffff);
        r(OPC_ADD, 32'h3f80_0000, 32'h3f80_0000, 7'h02, 32'h3380_0000, 1'b0, 32'h0, RM_NEAR);
        r(OPC_ADD, 32'h3f80_0000, 32'h3f80_0000, 7'h02, 32'h3380_0000, 1'b0, 32'h0, RM_ZERO);
        r(OPC_ADD, 32'h3f80_0000, 32'h3f80_0001, 7'h02, 32'h3380_0000, 1'b0, 32'h0, RM_UP);
        r(OPC_ADD, 32'hbf80_0000, 32'hbf80_0001, 7'h02, 32'hb380_0000, 1'b0, 32'h0, RM_DOWN);
        r(OPC_ADD_PROBE, 32'h7f7f_ffff, 32'h0000_0002, 7'h00, 32'h3f80_0000);
        r(OPC_ADD_PROBE, 32'h00c0_0000, 32'h0000_0046, 7'h00, 32'h8080_0000);
        r(8'h15, 32'h4040_0000, NW, 7'h00);
        repeat (16) @(negedge clock);
        srst = 1'b0;
        chk(32'(wb_valid), 32'h0);
        chk(32'(program_status_word), 32'h0);
        foreach (rows[i]) begin
            pulse(1'b1, 7'h00, 1'b0, 7'h00);
            fau_issue_model_i.issue(rows[i].op, rows[i].a, rows[i].b, rows[i].gg, rows[i].gw, rows[i].rm, 7'(i));
            fau_issue_model_i.idle();
            repeat (4) @(negedge clock);
            chk(fau_issue_model_i.rf[i], rows[i].e);
            chk(32'(program_status_word), 32'(rows[i].f));
        end
        // Back to back, commit meets a status write and another unit's set
        pulse(1'b1, 7'h01, 1'b0, 7'h00);
        fau_issue_model_i.issue(OPC_ABS, 32'hbf80_0000, 32'h0, 1'b0, 32'h0, RM_NEAR, 7'h64);
        fau_issue_model_i.issue(OPC_ADD, 32'h7f7f_ffff, 32'h7f7f_ffff, 1'b0, 32'h0, RM_NEAR, 7'h65);
        fau_issue_model_i.idle();
        pulse(1'b1, 7'h00, 1'b1, 7'h40);
        repeat (2) @(negedge clock);
        chk(fau_issue_model_i.rf[100], 32'h3f80_0000);
        chk(fau_issue_model_i.rf[101], 32'h7f80_0000);
        chk(32'(program_status_word), 32'h0000_004a);
        fau_issue_model_i.issue(OPC_ABS, 32'h4040_0000, 32'h0, 1'b0, 32'h0, RM_NEAR, 7'h66);
        fau_issue_model_i.idle();
        repeat (3) @(negedge clock);
        chk(32'(program_status_word), 32'h0000_004a);
        pulse(1'b0, 7'h00, 1'b1, 7'h01);
        chk(32'(program_status_word), 32'h0000_004b);
        pulse(1'b1, 7'h00, 1'b0, 7'h00);
        chk(32'(program_status_word), 32'h0);
        // Reset in mid-run with flags set and an operation issued on the reset edge
        pulse(1'b1, 7'h7f, 1'b0, 7'h00);
        fau_issue_model_i.issue(OPC_ADD, 32'h7f7f_ffff, 32'h7f7f_ffff, 1'b0, 32'h0, RM_NEAR, 7'h67);
        srst = 1'b1;
        fau_issue_model_i.idle();
        repeat (2) @(negedge clock);
        srst = 1'b0;
        chk(32'(wb_valid), 32'h0);
        chk(32'(program_status_word), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
